// ==== include/i2cee_pkg.sv ====
package i2cee_pkg;

  // ----------------------------------------
  // Byte framing
  // ----------------------------------------
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;

  // ----------------------------------------
  // Device select byte fields
  // ----------------------------------------
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CS_MSB = 3;
  localparam int SEL_CS_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam logic SEL_RW_READ = 1'b1;

  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int ADDR_BITS_LARGE = 13;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam int ADDR_HI_LSB = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int WRITE_CYCLE_CYCLES_DEFAULT = 1000;

  // ----------------------------------------
  // Protocol states
  // ----------------------------------------
  typedef enum logic [6:0] {
    I2CEE_IDLE = 7'h01,
    I2CEE_DEVSEL = 7'h02,
    I2CEE_ADDR_HI = 7'h04,
    I2CEE_ADDR_LO = 7'h08,
    I2CEE_WDATA = 7'h10,
    I2CEE_RDATA = 7'h20,
    I2CEE_RACK = 7'h40
  } i2cee_state_t;

endpackage : i2cee_pkg

// ==== rtl/i2cee_slave.sv ====
`timescale 1ns/1ps
// Overview of operation
// R1 - Each incoming data bit is sampled on a rising serial clock edge.
// R2 - Master keeps data stable while clock rises, changes it only when low.
// R3 - After start, master sends select byte MSB first: type, chip select, direction.
// R4 - Respond only when select bits b3..b1 equal the three chip-select pins.
// R5 - Select bit zero high means read, low means write.
// R6 - On a matching select code, pull data low in the ninth bit time.
// R7 - On a mismatch, release the bus, no acknowledge, wait for next start.
// R8 - Byte address is sixteen bits, high byte first then low byte.
// R9 - Unused high address bits are ignored by this memory size.
// R10 - Write: acknowledge select and both address bytes, then await data.
// R11 - Inhibit pin high before data: acknowledge address, refuse data, keep memory.
// R12 - Page write takes up to 32 bytes, all inside one row.
// R13 - After each written byte only the five low address bits increment.
// R14 - Write cycle starts only on stop right after a data acknowledge.
// R15 - During the write cycle all bus traffic is ignored.
// R16 - Busy device withholds select acknowledge; acknowledges once the cycle ends.
// R17 - Reads work whatever level the inhibit pin has.
// R18 - Random read: dummy write, repeated start, read select, one byte, no ack.
// R19 - Current read returns byte at address counter, then increments the counter.
// R20 - Master repeats identical upper select bits in a random read.
// R21 - Start is data falling while clock high; stop is data rising then.
// R22 - Sequential read: master ack fetches next byte; counter wraps to zero.
// R23 - No master acknowledge after a read byte ends transfer into standby.
// R24 - Data line is only pulled low or released, never driven high.
// R25 - Write cycle length is a parameter counted in clock cycles.
// R26 - Row overrun overwrites earlier buffered bytes at the wrapped position.
module i2cee_slave #(
  parameter int ADDR_BITS = i2cee_pkg::ADDR_BITS_LARGE,
  parameter int WRITE_CYCLE_CYCLES = i2cee_pkg::WRITE_CYCLE_CYCLES_DEFAULT,
  // Arbitrary neutral value, not any real maker code
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Strap pins
  input wire logic chip_select_pin_bit0,
  input wire logic chip_select_pin_bit1,
  input wire logic chip_select_pin_bit2,
  input wire logic write_inhibit_pin,
  // Status
  output logic write_cycle_busy
);

  // ----------------------------------------
  // Derived sizes
  // ----------------------------------------
  localparam int MEM_BYTES = 1 << ADDR_BITS;
  localparam int ROW_BITS = ADDR_BITS - i2cee_pkg::PAGE_BITS;
  localparam int HI_BITS = ADDR_BITS - i2cee_pkg::ADDR_HI_LSB;
  localparam int WCW = $clog2(WRITE_CYCLE_CYCLES + 1);
  localparam logic [WCW-1:0] WC_LAST = WCW'(WRITE_CYCLE_CYCLES - 1);
  localparam logic [WCW-1:0] WC_PAGE = WCW'(i2cee_pkg::PAGE_BYTES);

  // ----------------------------------------
  // Register image
  // ----------------------------------------
  typedef struct packed {
    // Two-flop synchronisers and edge history
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [2:0] cs_s1;
    logic [2:0] cs_s2;
    logic wp_s1;
    logic wp_s2;
    // Protocol engine
    i2cee_pkg::i2cee_state_t state;
    logic [3:0] bitcnt;
    logic ack_phase;
    logic drive;
    logic [7:0] shreg;
    logic [ADDR_BITS-1:0] addr;
    logic inhibit;
    logic stop_arm;
    logic mack;
    // Write cycle and page buffer
    logic busy;
    logic [WCW-1:0] wcnt;
    logic [i2cee_pkg::PAGE_BYTES-1:0] pvalid;
    logic [i2cee_pkg::PAGE_BYTES-1:0][7:0] pbuf;
    // Cells are flops cleared by reset; contents do not survive it
    logic [MEM_BYTES-1:0][7:0] mem;
  } i2cee_regs_t;

  // Clock and data sync stages start at the idle-high bus level, so reset leaves no false edge
  localparam i2cee_regs_t R_RESET = '{
    state: i2cee_pkg::I2CEE_IDLE,
    scl_s1: 1'b1,
    scl_s2: 1'b1,
    scl_d: 1'b1,
    sda_s1: 1'b1,
    sda_s2: 1'b1,
    sda_d: 1'b1,
    default: '0
  };

  i2cee_regs_t r;
  i2cee_regs_t next_r;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic i2cee_is_rx(input i2cee_pkg::i2cee_state_t s);
    return (s == i2cee_pkg::I2CEE_DEVSEL) || (s == i2cee_pkg::I2CEE_ADDR_HI) ||
           (s == i2cee_pkg::I2CEE_ADDR_LO) || (s == i2cee_pkg::I2CEE_WDATA);
  endfunction : i2cee_is_rx

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sel_match;
    logic [i2cee_pkg::PAGE_BITS-1:0] widx;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    bus_start = 1'b0;
    bus_stop = 1'b0;
    sel_match = 1'b0;
    widx = '0;
    next_r = r;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Strap pins may be driven dynamically, so they pass two flops as well
    next_r.scl_s1 = scl_in;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_d = r.scl_s2;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_d = r.sda_s2;
    next_r.cs_s1 = {chip_select_pin_bit2, chip_select_pin_bit1, chip_select_pin_bit0};
    next_r.cs_s2 = r.cs_s1;
    next_r.wp_s1 = write_inhibit_pin;
    next_r.wp_s2 = r.wp_s1;

    // ----------------------------------------
    // Bus conditions
    // ----------------------------------------
    scl_rise = r.scl_s2 & ~r.scl_d;
    scl_fall = ~r.scl_s2 & r.scl_d;
    bus_start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2; // [R21]
    bus_stop = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2; // [R21]
    sel_match = (r.shreg[i2cee_pkg::SEL_TYPE_MSB:i2cee_pkg::SEL_TYPE_LSB] == DEVICE_TYPE_ID) &&
                (r.shreg[i2cee_pkg::SEL_CS_MSB:i2cee_pkg::SEL_CS_LSB] == r.cs_s2); // [R4]

    if (r.busy) begin
      // ----------------------------------------
      // Write cycle
      // ----------------------------------------
      // Commit takes one clock per page byte, so the cycle may not be shorter than a page
      // Bus is deaf while cells program; buffered bytes commit one per clock
      next_r.drive = 1'b0; // [R15] [R16]
      next_r.wcnt = r.wcnt + 1'b1; // [R25]
      if (r.wcnt < WC_PAGE) begin
        widx = r.wcnt[i2cee_pkg::PAGE_BITS-1:0];
        if (r.pvalid[widx]) begin
          next_r.mem[{r.addr[ADDR_BITS-1:i2cee_pkg::PAGE_BITS], widx}] = r.pbuf[widx]; // [R12]
        end
      end
      if (r.wcnt == WC_LAST) begin
        next_r.busy = 1'b0; // [R16]
        next_r.pvalid = '0;
      end
    end else if (bus_start) begin
      // ----------------------------------------
      // Start and stop
      // ----------------------------------------
      // Repeated start also lands here; dropping buffered data makes a dummy write harmless
      next_r.state = i2cee_pkg::I2CEE_DEVSEL; // [R3] [R18]
      next_r.bitcnt = i2cee_pkg::BIT_CNT_RESET;
      next_r.ack_phase = 1'b0;
      next_r.drive = 1'b0;
      next_r.stop_arm = 1'b0;
      next_r.pvalid = '0;
      next_r.inhibit = r.wp_s2; // [R11]
    end else if (bus_stop) begin
      if ((r.state == i2cee_pkg::I2CEE_WDATA) && r.stop_arm && (|r.pvalid)) begin
        next_r.busy = 1'b1; // [R14]
        next_r.wcnt = '0;
      end
      next_r.state = i2cee_pkg::I2CEE_IDLE;
      next_r.drive = 1'b0;
      next_r.ack_phase = 1'b0;
      next_r.stop_arm = 1'b0;
    end else if (i2cee_is_rx(r.state)) begin
      // ----------------------------------------
      // Receive path
      // ----------------------------------------
      if (r.state != i2cee_pkg::I2CEE_WDATA) begin
        next_r.inhibit = r.inhibit | r.wp_s2; // [R11]
      end
      if (scl_rise) begin
        if (r.bitcnt < i2cee_pkg::ACK_SLOT) begin
          next_r.shreg = {r.shreg[6:0], r.sda_s2}; // [R1] [R3]
          next_r.bitcnt = r.bitcnt + 1'b1;
        end
      end else if (scl_fall) begin
        if (r.bitcnt != i2cee_pkg::ACK_SLOT) begin
          // Arm only survives until the next clock low; stop must follow at once
          next_r.stop_arm = 1'b0; // [R14]
        end else if (!r.ack_phase) begin
          next_r.ack_phase = 1'b1;
          case (r.state)
            i2cee_pkg::I2CEE_DEVSEL: begin
              if (sel_match) begin
                next_r.drive = 1'b1; // [R6] [R10]
              end else begin
                next_r.state = i2cee_pkg::I2CEE_IDLE; // [R7]
                next_r.drive = 1'b0;
                next_r.ack_phase = 1'b0;
              end
            end
            i2cee_pkg::I2CEE_ADDR_HI: begin
              next_r.addr[ADDR_BITS-1:i2cee_pkg::ADDR_HI_LSB] = r.shreg[HI_BITS-1:0]; // [R8] [R9]
              next_r.drive = 1'b1; // [R10]
            end
            i2cee_pkg::I2CEE_ADDR_LO: begin
              next_r.addr[i2cee_pkg::ADDR_HI_LSB-1:0] = r.shreg; // [R8]
              next_r.drive = 1'b1; // [R10] [R11]
            end
            i2cee_pkg::I2CEE_WDATA: begin
              next_r.drive = ~r.inhibit; // [R11]
              if (!r.inhibit) begin
                widx = r.addr[i2cee_pkg::PAGE_BITS-1:0];
                next_r.pbuf[widx] = r.shreg; // [R26]
                next_r.pvalid[widx] = 1'b1;
                next_r.addr[i2cee_pkg::PAGE_BITS-1:0] = widx + 1'b1; // [R13]
              end
            end
            default: begin
              next_r.drive = 1'b0;
            end
          endcase
        end else begin
          next_r.ack_phase = 1'b0;
          next_r.drive = 1'b0;
          next_r.bitcnt = i2cee_pkg::BIT_CNT_RESET;
          case (r.state)
            i2cee_pkg::I2CEE_DEVSEL: begin
              if (r.shreg[i2cee_pkg::SEL_RW_BIT] == i2cee_pkg::SEL_RW_READ) begin
                // Read path never looks at the inhibit pin
                next_r.state = i2cee_pkg::I2CEE_RDATA; // [R5] [R17] [R19]
                next_r.shreg = r.mem[r.addr];
                next_r.drive = ~r.mem[r.addr][7]; // [R24]
                next_r.addr = r.addr + 1'b1; // [R19] [R22]
              end else begin
                next_r.state = i2cee_pkg::I2CEE_ADDR_HI; // [R5] [R10]
              end
            end
            i2cee_pkg::I2CEE_ADDR_HI: begin
              next_r.state = i2cee_pkg::I2CEE_ADDR_LO;
            end
            i2cee_pkg::I2CEE_ADDR_LO: begin
              next_r.state = i2cee_pkg::I2CEE_WDATA;
            end
            i2cee_pkg::I2CEE_WDATA: begin
              next_r.stop_arm = ~r.inhibit; // [R14]
            end
            default: begin
              next_r.state = i2cee_pkg::I2CEE_IDLE;
            end
          endcase
        end
      end
    end else begin
      // ----------------------------------------
      // Read stream
      // ----------------------------------------
      // Counter moves as each byte loads, so a later current read starts past it
      case (r.state)
        i2cee_pkg::I2CEE_RDATA: begin
          if (scl_rise) begin
            next_r.bitcnt = r.bitcnt + 1'b1;
          end else if (scl_fall) begin
            if (r.bitcnt == i2cee_pkg::ACK_SLOT) begin
              next_r.drive = 1'b0;
              next_r.state = i2cee_pkg::I2CEE_RACK;
              next_r.mack = 1'b0;
            end else if (r.bitcnt != i2cee_pkg::BIT_CNT_RESET) begin
              next_r.shreg = {r.shreg[6:0], 1'b0};
              next_r.drive = ~r.shreg[6]; // [R24]
            end
          end
        end
        i2cee_pkg::I2CEE_RACK: begin
          if (scl_rise) begin
            // Master answer taken at the clock rise, where the line is stable
            next_r.mack = ~r.sda_s2; // [R23]
          end else if (scl_fall) begin
            if (r.mack) begin
              next_r.state = i2cee_pkg::I2CEE_RDATA; // [R22]
              next_r.bitcnt = i2cee_pkg::BIT_CNT_RESET;
              next_r.shreg = r.mem[r.addr];
              next_r.drive = ~r.mem[r.addr][7];
              next_r.addr = r.addr + 1'b1; // [R22]
            end else begin
              next_r.state = i2cee_pkg::I2CEE_IDLE; // [R18] [R23]
              next_r.drive = 1'b0;
            end
          end
        end
        default: begin
          next_r.drive = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= R_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: output level is always low, only the enable moves
  assign sda_out = 1'b0; // [R24]
  assign sda_oe_n = ~r.drive; // [R24]
  assign write_cycle_busy = r.busy;

endmodule : i2cee_slave

// ==== bench/i2cee_master.sv ====
`timescale 1ns/1ps
module i2cee_master (
  // Clock and bus, data is open drain
  input wire logic clk,
  output logic scl,
  input wire logic sda,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Start is frame(1, 0), stop is frame(0, 1)
  task automatic frame(input logic a, input logic b);
    sda_drv <= a;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_drv <= b;
    tick(2);
    scl <= b;
    tick(4);
  endtask : frame
  // Byte plus acknowledge slot; data moves only while the clock is low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= d[i];
      tick(2);
      scl <= 1'b1;
      tick(3);
      q[i] = sda;
      tick(1);
      scl <= 1'b0;
      tick(2);
    end
  endtask : xfer
endmodule : i2cee_master

// ==== bench/i2cee_slave_chk.sv ====
`timescale 1ns/1ps
module i2cee_slave_chk #(
  parameter int WRITE_CYCLE_CYCLES = 1000
) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic write_cycle_busy
);
  logic sda_q;
  logic [3:0] stop_age;
  logic [3:0] high_run;
  int busy_run;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= 1'b1;
      stop_age <= 4'hF;
      high_run <= 4'h0;
      busy_run <= 0;
    end else begin
      sda_q <= sda_in;
      stop_age <= (scl_in && sda_in && !sda_q) ? 4'h0 : stop_age + 4'(stop_age != 4'hF);
      high_run <= scl_in ? high_run + 4'(high_run != 4'hF) : 4'h0;
      busy_run <= write_cycle_busy ? busy_run + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  drive_low_only_a: assert property (!sda_oe_n |-> !sda_out)
    else $error("data driven high");
  busy_quiet_a: assert property (write_cycle_busy && $past(write_cycle_busy) |-> sda_oe_n)
    else $error("drive while busy");
  busy_length_a: assert property ($fell(write_cycle_busy) |-> busy_run == WRITE_CYCLE_CYCLES)
    else $error("write cycle length");
  cycle_on_stop_a: assert property ($rose(write_cycle_busy) |-> stop_age < 4'h8)
    else $error("write cycle without stop");
  change_clock_low_a: assert property ($changed(sda_oe_n) |-> !$past(scl_in, 3))
    else $error("data changed with clock high");
  ack_holds_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*7])
    else $error("low bit too short");
  release_holds_a: assert property ($rose(sda_oe_n) |-> sda_oe_n [*6])
    else $error("release too short");
  idle_released_a: assert property (high_run > 4'h8 |-> sda_oe_n)
    else $error("drive while bus idle");
endmodule : i2cee_slave_chk
bind i2cee_slave i2cee_slave_chk #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .write_cycle_busy(write_cycle_busy));

// ==== bench/i2cee_slave_bench.sv ====
`timescale 1ns/1ps
module i2cee_slave_bench;
  localparam int WCYC = 100;
  // Arbitrary type code, shared by bench and device
  localparam logic [3:0] TID = 4'h9;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] cs = 3'h0;
  logic inh = 1'b0;
  logic scl;
  logic drv;
  logic oe_n;
  logic sda_out;
  logic busy;
  wire sda = drv & (oe_n | sda_out);
  logic [31:0] seed = 32'hC743C18E;
  logic [7:0] mem [8192];
  logic [12:0] cur = 13'h0;
  logic [8:0] q;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  i2cee_slave #(.WRITE_CYCLE_CYCLES(WCYC), .DEVICE_TYPE_ID(TID)) u_dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(oe_n),
    .chip_select_pin_bit0(cs[0]), .chip_select_pin_bit1(cs[1]), .chip_select_pin_bit2(cs[2]),
    .write_inhibit_pin(inh), .write_cycle_busy(busy));
  i2cee_master u_mst (.clk(clk), .scl(scl), .sda(sda), .sda_drv(drv));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Row-wrapped position of the k-th written byte
  function automatic logic [12:0] wpos(input logic [15:0] ad, input int k);
    return {ad[12:5], ad[4:0] + 5'(k)};
  endfunction : wpos
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic sel(input logic [3:0] id, input logic [2:0] c, input logic rw);
    u_mst.frame(1'b1, 1'b0);
    u_mst.xfer({id, c, rw, 1'b1}, q);
  endtask : sel
  // Poll up to five times until taken, then load the address
  task automatic cmd(input logic [15:0] ad, input logic busy_exp);
    sel(TID, cs, 1'b0);
    check("poll", 8'(q[0]), 8'(busy_exp));
    for (int k = 0; k < 4 && q[0] !== 1'b0; k++) begin
      sel(TID, cs, 1'b0);
    end
    check("select", 8'(q[0]), 8'h0);
    u_mst.xfer({ad[15:8], 1'b1}, q);
    check("addr high", 8'(q[0]), 8'h0);
    u_mst.xfer({ad[7:0], 1'b1}, q);
    check("addr low", 8'(q[0]), 8'h0);
    cur = ad[12:0];
  endtask : cmd
  task automatic rd(input int n);
    sel(TID, cs, 1'b1);
    check("read select", 8'(q[0]), 8'h0);
    for (int k = 0; k < n; k++) begin
      u_mst.xfer({8'hFF, k == n - 1}, q);
      check("read data", q[8:1], mem[cur]);
      cur++;
    end
    u_mst.frame(1'b0, 1'b1);
  endtask : rd
  task automatic pw(input logic [15:0] ad, input int n);
    logic [7:0] d;
    cmd(ad, 1'b0);
    for (int k = 0; k < n; k++) begin
      d = 8'(rnd());
      u_mst.xfer({d, 1'b1}, q);
      check("data ack", 8'(q[0]), 8'(inh));
      if (!inh) begin
        mem[wpos(ad, k)] = d;
      end
    end
    u_mst.frame(1'b0, 1'b1);
    check("write cycle", 8'(busy), 8'(!inh));
  endtask : pw
  initial begin
    logic [15:0] ad;
    int n;
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'h00;
    end
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      cs <= 3'(i);
      @(posedge clk);
      rd(1);
      sel(TID, cs ^ 3'(1 + rnd() % 7), 1'b1);
      check("foreign select", 8'(q[0]), 8'h1);
      sel(~TID, cs, 1'b1);
      check("foreign type", 8'(q[0]), 8'h1);
      u_mst.frame(1'b0, 1'b1);
    end
    $display("test select decode done");
    cmd(16'h0040, 1'b0);
    u_mst.frame(1'b0, 1'b1);
    check("early stop", 8'(busy), 8'h0);
    $display("test early stop done");
    for (int i = 0; i < 4; i++) begin
      ad = (i == 0) ? 16'hE01C : 16'(rnd());
      n = (i == 0) ? 34 : 1 + int'(rnd() % 32);
      inh <= (i == 2);
      @(posedge clk);
      pw(ad, n);
      cmd(ad, !inh);
      rd(n);
      $display("test page write %0d done", i);
    end
    inh <= 1'b1;
    cmd(16'hFFFF, 1'b0);
    rd(2);
    rd(1);
    $display("test address wrap done");
    results();
  end
endmodule : i2cee_slave_bench
